// file: src/scan_sensor_sequencer.sv
`include "scan_seq_params.svh"
module scan_sensor_sequencer (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic ACLK_IN,
  input wire logic SCAN_ENABLE,
  input wire logic SEQUENCER_REPEAT,
  input wire logic [1:0] FAST_CLOCK_DIV,
  input wire logic [1:0] START_DIVIDER_FIRST,
  input wire logic [7:0] START_DIVIDER_SECOND_A,
  input wire logic [7:0] START_DIVIDER_SECOND_B,
  input wire logic TABLE_WE,
  input wire logic [4:0] TABLE_ADDR,
  input wire scan_seq_pkg::entry_t TABLE_WDATA,
  input wire logic LEVEL_WE,
  input wire logic [2:0] LEVEL_ADDR,
  input wire logic [9:0] LEVEL_WDATA,
  input wire logic DIRECT_INPUT_SELECT,
  input wire logic SAMPLE_HOLD_SELECT,
  input wire logic ENVELOPE_INPUT_SELECT,
  input wire logic DIRECT_CHANNEL3_SELECT,
  input wire logic [1:0] TEST0_CHANNEL_FIELD,
  input wire logic [1:0] TEST1_CHANNEL_FIELD,
  input wire logic TEST_REQUEST_SET,
  input wire logic COMPARATOR_INVERT,
  input wire logic COMPARATOR_FORCE_ON,
  input wire logic DAC_FORCE_ON,
  input wire logic TIMER_OUTPUT_MODE,
  input wire logic [1:0] TIMER_ROUTE_SELECT_A,
  input wire logic [1:0] TIMER_ROUTE_SELECT_B,
  input wire logic START_FLAG_CLR,
  input wire logic STOP_FLAG_CLR,
  input wire logic COMPARATOR_OUT,
  output logic [1:0] CHANNEL_SELECT,
  output logic SENSOR_PATH_EXCITE,
  output logic SENSOR_PATH_SAMPLE,
  output logic DIRECT_PATH,
  output logic COMMON_DIRECT_INPUT,
  output logic LC_SENSOR_ENABLE,
  output logic EXCITATION_PULSE,
  output logic COMPARATOR_POWER,
  output logic DAC_POWER,
  output logic [9:0] DAC_LEVEL,
  output logic OSC_ENABLE,
  output logic SEQUENCE_STOP,
  output logic [3:0] CHANNEL_RESULT_BIT,
  output logic TEST0_RESULT_BIT,
  output logic TEST1_RESULT_BIT,
  output logic TEST_CYCLE_REQUEST,
  output logic TEST_CYCLE_ACTIVE,
  output logic SEQUENCE_START_FLAG,
  output logic SEQUENCE_STOP_FLAG,
  output logic [2:0] TIMER_CAPTURE
);
  import scan_seq_pkg::*;

  // ******************************
  // input synchronisers
  // ******************************
  logic aclk_m_ff, aclk_s_ff, cmp_m_ff, cmp_s_ff;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aclk_m_ff <= 1'b0;
      aclk_s_ff <= 1'b0;
      cmp_m_ff <= 1'b0;
      cmp_s_ff <= 1'b0;
    end else begin
      aclk_m_ff <= ACLK_IN;
      aclk_s_ff <= aclk_m_ff;
      cmp_m_ff <= COMPARATOR_OUT;
      cmp_s_ff <= cmp_m_ff;
    end
  end

  seq_ctl_if ctl ();
  scan_clk_div u_div (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .en(SCAN_ENABLE),
    .slow_clk_s(aclk_s_ff),
    .fast_div(FAST_CLOCK_DIV),
    .div_first(START_DIVIDER_FIRST),
    .div_a(START_DIVIDER_SECOND_A),
    .div_b(START_DIVIDER_SECOND_B),
    .ctl(ctl.div)
  );

  // ******************************
  // state table and level registers
  // ******************************
  entry_t table_mem [`NUM_ENTRIES];
  logic [`DAC_W-1:0] level_mem [`NUM_LEVELS];
  always_ff @(posedge SYS_CLK) begin
    if (TABLE_WE && TABLE_ADDR < 5'(`NUM_ENTRIES)) table_mem[TABLE_ADDR] <= TABLE_WDATA;
    if (LEVEL_WE) level_mem[LEVEL_ADDR] <= LEVEL_WDATA;
  end

  // ******************************
  // sequencer
  // ******************************
  seq_state_t st_ff;
  logic [4:0] ptr_ff;
  logic [4:0] rpt_ff;
  logic pending_ff;
  logic stop_ff;
  entry_t cur;
  logic tick;
  logic last_tick;
  logic [4:0] nxt_ptr;
  assign cur = table_mem[ptr_ff];
  assign tick = cur[`ENT_SLOW] ? ctl.slow_tick : ctl.fast_tick;
  assign last_tick = tick && rpt_ff == cur[`ENT_RPT_LSB +: `ENT_RPT_W];
  assign nxt_ptr = ptr_ff + 5'h1;
  assign ctl.load_divider = (st_ff == SQ_STOP);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= SQ_IDLE;
      ptr_ff <= 5'h00;
      rpt_ff <= 5'h00;
      pending_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else if (!SCAN_ENABLE) begin
      st_ff <= SQ_IDLE;
      ptr_ff <= 5'h00;
      rpt_ff <= 5'h00;
      pending_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else begin
      stop_ff <= 1'b0;
      unique case (st_ff)
        SQ_IDLE: begin
          // entry 0 is held while idle
          rpt_ff <= 5'h00;
          if (ctl.start_tick || (pending_ff && ctl.slow_tick)) begin
            st_ff <= SQ_RUN;
            pending_ff <= 1'b0;
          end
        end
        SQ_RUN: begin
          if (cur[`ENT_STOP]) begin
            if (ctl.fast_tick) begin
              st_ff <= SQ_STOP;
              stop_ff <= 1'b1;
            end
          end else if (last_tick) begin
            rpt_ff <= 5'h00;
            ptr_ff <= (nxt_ptr >= 5'(`NUM_ENTRIES)) ? 5'h00 : nxt_ptr;
          end else if (tick) rpt_ff <= rpt_ff + 5'h01;
        end
        SQ_STOP: begin
          st_ff <= SQ_IDLE;
          ptr_ff <= 5'h00;
          rpt_ff <= 5'h00;
          pending_ff <= SEQUENCER_REPEAT;
        end
        default: st_ff <= SQ_IDLE;
      endcase
    end
  end

  // ******************************
  // test cycle control
  // ******************************
  logic req_ff, tact_ff;
  logic seq_start;
  assign seq_start = (st_ff == SQ_IDLE) && SCAN_ENABLE &&
                     (ctl.start_tick || (pending_ff && ctl.slow_tick));
  // test cycle armed at a sequence stop, runs as the next sequence from its start
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_ff <= 1'b0;
      tact_ff <= 1'b0;
    end else begin
      if (stop_ff && tact_ff) begin
        tact_ff <= 1'b0;
        req_ff <= TEST_REQUEST_SET;
      end else begin
        if (stop_ff && req_ff) tact_ff <= 1'b1;
        if (TEST_REQUEST_SET) req_ff <= 1'b1;
      end
    end
  end
  logic test_run;
  assign test_run = tact_ff && (st_ff == SQ_IDLE);

  // ******************************
  // channel, result bit and reference selection
  // ******************************
  logic sel_test;
  logic [1:0] in_chan;
  assign sel_test = cur[`ENT_TS];
  always_comb begin
    if (tact_ff) in_chan = sel_test ? TEST1_CHANNEL_FIELD : TEST0_CHANNEL_FIELD;
    else in_chan = cur[`ENT_CH_LSB +: 2];
  end

  function automatic logic [2:0] level_index(input logic [1:0] ch, input logic last);
    level_index = {ch, last};
  endfunction : level_index

  logic [2:0] lvl_idx;
  always_comb begin
    if (tact_ff) lvl_idx = sel_test ? `TEST_LVL1 : `TEST_LVL0;
    else lvl_idx = level_index(in_chan, CHANNEL_RESULT_BIT[in_chan]);
  end

  // ******************************
  // result latch and result bits
  // ******************************
  logic cmp_res;
  logic latch_ff;
  assign cmp_res = cmp_s_ff ^ COMPARATOR_INVERT;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) latch_ff <= 1'b0;
    else if (!cur[`ENT_RS] || st_ff != SQ_RUN) latch_ff <= 1'b0;
    else if (cmp_res) latch_ff <= 1'b1;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CHANNEL_RESULT_BIT <= 4'h0;
      TEST0_RESULT_BIT <= 1'b0;
      TEST1_RESULT_BIT <= 1'b0;
    end else if (stop_ff) begin
      if (tact_ff && sel_test) TEST1_RESULT_BIT <= latch_ff;
      else if (tact_ff) TEST0_RESULT_BIT <= latch_ff;
      else if (DIRECT_INPUT_SELECT && ENVELOPE_INPUT_SELECT) CHANNEL_RESULT_BIT <= {4{latch_ff}};
      else CHANNEL_RESULT_BIT[in_chan] <= latch_ff;
    end
  end

  // ******************************
  // front-end drive
  // ******************************
  logic run_en;
  assign run_en = SCAN_ENABLE;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CHANNEL_SELECT <= 2'h0;
      SENSOR_PATH_EXCITE <= 1'b0;
      SENSOR_PATH_SAMPLE <= 1'b0;
      DIRECT_PATH <= 1'b0;
      COMMON_DIRECT_INPUT <= 1'b0;
      LC_SENSOR_ENABLE <= 1'b0;
      EXCITATION_PULSE <= 1'b0;
      COMPARATOR_POWER <= 1'b0;
      DAC_POWER <= 1'b0;
      DAC_LEVEL <= 10'h000;
      OSC_ENABLE <= 1'b0;
      SEQUENCE_STOP <= 1'b0;
    end else begin
      CHANNEL_SELECT <= run_en ? in_chan : 2'h0;
      SENSOR_PATH_EXCITE <= ~DIRECT_INPUT_SELECT & ~SAMPLE_HOLD_SELECT;
      SENSOR_PATH_SAMPLE <= ~DIRECT_INPUT_SELECT & SAMPLE_HOLD_SELECT;
      DIRECT_PATH <= DIRECT_INPUT_SELECT;
      COMMON_DIRECT_INPUT <= DIRECT_INPUT_SELECT &
                             (ENVELOPE_INPUT_SELECT | DIRECT_CHANNEL3_SELECT);
      LC_SENSOR_ENABLE <= run_en & cur[`ENT_LC];
      EXCITATION_PULSE <= run_en & cur[`ENT_EX];
      COMPARATOR_POWER <= COMPARATOR_FORCE_ON | (run_en & cur[`ENT_CA]);
      DAC_POWER <= DAC_FORCE_ON | (run_en & cur[`ENT_DAC]);
      DAC_LEVEL <= level_mem[lvl_idx];
      OSC_ENABLE <= run_en;
      SEQUENCE_STOP <= run_en & stop_ff;
    end
  end

  // ******************************
  // flags and timer routing
  // ******************************
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SEQUENCE_START_FLAG <= 1'b0;
      SEQUENCE_STOP_FLAG <= 1'b0;
      TEST_CYCLE_REQUEST <= 1'b0;
      TEST_CYCLE_ACTIVE <= 1'b0;
    end else begin
      if (seq_start) SEQUENCE_START_FLAG <= 1'b1;
      else if (START_FLAG_CLR) SEQUENCE_START_FLAG <= 1'b0;
      if (stop_ff) SEQUENCE_STOP_FLAG <= 1'b1;
      else if (STOP_FLAG_CLR) SEQUENCE_STOP_FLAG <= 1'b0;
      TEST_CYCLE_REQUEST <= req_ff;
      TEST_CYCLE_ACTIVE <= tact_ff | test_run;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) TIMER_CAPTURE <= 3'h0;
    else if (TIMER_OUTPUT_MODE) TIMER_CAPTURE <= {1'b0, cmp_res, cur[`ENT_EX] & run_en};
    else TIMER_CAPTURE <= {1'b0, CHANNEL_RESULT_BIT[TIMER_ROUTE_SELECT_B],
                           CHANNEL_RESULT_BIT[TIMER_ROUTE_SELECT_A]};
  end
endmodule : scan_sensor_sequencer

// file: src/scan_seq_params.svh
`ifndef SCAN_SEQ_PARAMS_SVH
`define SCAN_SEQ_PARAMS_SVH
// Overview of operation
// - direct select picks direct pins; else sensor pins via excitation or sample-hold path
// - outside test, state channel code picks excited channel and result bit 0..3
// - in test, test select state picks test0 or test1 channel and result bit
// - test cycle active derives from software test cycle request bit
// - with direct select, envelope and channel3 select pick common or separate inputs
// - latch sets on comparator high while latch enable high, else held reset
// - latch value moves into selected result bit on rising edge of stop
// - comparator high when input above reference; optional inversion before storage
// - comparator and dac powered by state bits or their force-on bits
// - outside test, level register index is twice channel plus last result bit
// - in test, level register 6 or 7 by test select state
// - timer output mode 1 routes excitation and comparator to capture inputs
// - timer output mode 0 routes two selected result bits to capture inputs
// - sequencer walks 24 entries of 16 bits from entry 0
// - scan enable low resets divider, start flop, outputs and stops oscillator; path select, dac level, result, flag and capture outputs are not reset
// - stop state resets counter and halts; restart on start or on next slow clock cycle by repeat
// - after stop pulse, entry 0 settings are driven until next sequence
// - repeat 0 starts sequences from divided slow clock start pulse
// - repeat 1 restarts on next slow clock cycle; start flag set each start
// - second-stage divider writes apply from next sequence stop
// - each control output follows its table bit for the whole state
// - state lasts repeat count plus one cycles of slow or fast clock
// - stop state lasts one fast cycle and sets stop flag
// - test request runs test cycle after next sequence, clears when it ends
// entry field positions
`define ENT_CH_LSB 0
`define ENT_LC 2
`define ENT_EX 3
`define ENT_CA 4
`define ENT_RS 5
`define ENT_TS 6
`define ENT_DAC 7
`define ENT_STOP 8
`define ENT_SLOW 9
`define ENT_RPT_LSB 10
`define ENT_RPT_W 5
`define NUM_ENTRIES 24
`define ENTRY_W 16
`define DAC_W 10
`define NUM_LEVELS 8
`define TEST_LVL0 3'h6
`define TEST_LVL1 3'h7
`endif

// file: src/scan_seq_pkg.sv
package scan_seq_pkg;
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_RUN = 2'b01,
    SQ_STOP = 2'b10
  } seq_state_t;
  typedef logic [15:0] entry_t;
endpackage : scan_seq_pkg

// file: src/seq_ctl_if.sv
interface seq_ctl_if;
  logic fast_tick;
  logic slow_tick;
  logic start_tick;
  logic load_divider;
  modport div (output fast_tick, output slow_tick, output start_tick, input load_divider);
  modport seq (input fast_tick, input slow_tick, input start_tick, output load_divider);
endinterface : seq_ctl_if

// file: src/scan_clk_div.sv
`include "scan_seq_params.svh"
module scan_clk_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic slow_clk_s,
  input wire logic [1:0] fast_div,
  input wire logic [1:0] div_first,
  input wire logic [7:0] div_a,
  input wire logic [7:0] div_b,
  seq_ctl_if.div ctl
);
  logic slow_d_ff;
  logic [7:0] fcnt_ff;
  logic [2:0] c1_ff;
  logic [15:0] c2_ff;
  logic [15:0] period_ff;
  logic edge_w;
  logic [15:0] nxt_period;
  assign edge_w = slow_clk_s & ~slow_d_ff;
  // period held minus one so that (255+1)*(255+1) still fits in 16 bits
  assign nxt_period = 16'(div_a) * 16'(div_b) + 16'(div_a) + 16'(div_b);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) slow_d_ff <= 1'b0;
    else slow_d_ff <= slow_clk_s;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fcnt_ff <= 8'h00;
      ctl.fast_tick <= 1'b0;
    end else if (!en) begin
      fcnt_ff <= 8'h00;
      ctl.fast_tick <= 1'b0;
    end else begin
      ctl.fast_tick <= (fcnt_ff == 8'h00);
      fcnt_ff <= (fcnt_ff >= 8'((8'h1 << fast_div) - 8'h1)) ? 8'h00 : fcnt_ff + 8'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ctl.slow_tick <= 1'b0;
    else ctl.slow_tick <= en & edge_w;
  end
  // first stage /1/2/4/8 then second stage (a+1)*(b+1) slow clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c1_ff <= 3'h0;
      c2_ff <= 16'h0000;
      period_ff <= 16'h0000;
      ctl.start_tick <= 1'b0;
    end else if (!en) begin
      c1_ff <= 3'h0;
      c2_ff <= 16'h0000;
      period_ff <= nxt_period;
      ctl.start_tick <= 1'b0;
    end else begin
      ctl.start_tick <= 1'b0;
      if (ctl.load_divider) period_ff <= nxt_period;
      if (edge_w) begin
        if (c1_ff >= 3'((4'h1 << div_first) - 4'h1)) begin
          c1_ff <= 3'h0;
          if (c2_ff >= period_ff) begin
            c2_ff <= 16'h0000;
            ctl.start_tick <= 1'b1;
          end else c2_ff <= c2_ff + 16'h1;
        end else c1_ff <= c1_ff + 3'h1;
      end
    end
  end
endmodule : scan_clk_div

// file: tb/scan_seq_sva.sv
module scan_seq_sva (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SCAN_ENABLE,
  input wire logic COMPARATOR_FORCE_ON,
  input wire logic DAC_FORCE_ON,
  input wire logic TIMER_OUTPUT_MODE,
  input wire logic [1:0] TIMER_ROUTE_SELECT_A,
  input wire logic STOP_FLAG_CLR,
  input wire logic [1:0] CHANNEL_SELECT,
  input wire logic EXCITATION_PULSE,
  input wire logic COMPARATOR_POWER,
  input wire logic DAC_POWER,
  input wire logic SEQUENCE_STOP,
  input wire logic [3:0] CHANNEL_RESULT_BIT,
  input wire logic TEST_CYCLE_REQUEST,
  input wire logic TEST_CYCLE_ACTIVE,
  input wire logic SEQUENCE_STOP_FLAG,
  input wire logic [2:0] TIMER_CAPTURE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // ****************
  // steps
  // ****************
  sequence route_steady;
    SCAN_ENABLE && !TIMER_OUTPUT_MODE && $stable(TIMER_ROUTE_SELECT_A)
      && $stable(CHANNEL_RESULT_BIT);
  endsequence
  sequence stop_seen;
    SEQUENCE_STOP || $past(SEQUENCE_STOP) || $past(SEQUENCE_STOP, 2);
  endsequence
  dis_clear_a: assert property (!SCAN_ENABLE [*2] |->
    !SEQUENCE_STOP && !EXCITATION_PULSE && CHANNEL_SELECT == 2'h0) else $error("output while off");
  stop_pulse_a: assert property (SEQUENCE_STOP |=> !SEQUENCE_STOP)
    else $error("stop pulse too long");
  stop_flag_a: assert property (SEQUENCE_STOP |-> ##[0:1] SEQUENCE_STOP_FLAG)
    else $error("stop flag not set");
  flag_hold_a: assert property (SEQUENCE_STOP_FLAG && !STOP_FLAG_CLR && SCAN_ENABLE
    |=> SEQUENCE_STOP_FLAG) else $error("stop flag lost");
  cmp_force_a: assert property (SCAN_ENABLE && COMPARATOR_FORCE_ON |=> COMPARATOR_POWER)
    else $error("comparator not forced on");
  dac_force_a: assert property (SCAN_ENABLE && DAC_FORCE_ON |=> DAC_POWER)
    else $error("dac not forced on");
  route_sel_a: assert property (route_steady [*2] |->
    TIMER_CAPTURE[0] == CHANNEL_RESULT_BIT[TIMER_ROUTE_SELECT_A]) else $error("bad route");
  test_rise_a: assert property ($rose(TEST_CYCLE_ACTIVE) |-> $past(TEST_CYCLE_REQUEST))
    else $error("test without request");
  test_end_a: assert property ($fell(TEST_CYCLE_ACTIVE) && SCAN_ENABLE
    |-> ##[0:1] !TEST_CYCLE_REQUEST) else $error("request not cleared");
  result_move_a: assert property ($changed(CHANNEL_RESULT_BIT) && SCAN_ENABLE
    && $past(SCAN_ENABLE) |-> ##[0:2] stop_seen) else $error("result moved off stop");
endmodule : scan_seq_sva
bind scan_sensor_sequencer scan_seq_sva u_sva (.*);

// file: tb/scan_afe_model.sv
module scan_afe_model (
  input wire logic clk,
  input wire logic [1:0] sel,
  input wire logic [9:0] level,
  input wire logic power,
  input wire logic [39:0] ain,
  output logic cmp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle_ff = 1'b0;
  // ****************
  // unpowered comparator wanders every cycle
  // ****************
  always @(posedge clk) begin
    idle_ff <= !idle_ff;
  end
  always_comb begin
    cmp_out = power ? (ain[sel * 10 +: 10] > level) : idle_ff;
  end
endmodule : scan_afe_model

// file: tb/scan_sensor_sequencer_tb.sv
module scan_sensor_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scan_seq_pkg::*;
  logic SYS_CLK = 0, RST_N = 0, ACLK_IN = 0, SCAN_ENABLE = 0, SEQUENCER_REPEAT = 0;
  logic [1:0] FAST_CLOCK_DIV = 0, START_DIVIDER_FIRST = 0, TEST0_CHANNEL_FIELD = 0;
  logic [7:0] START_DIVIDER_SECOND_A = 8'h03, START_DIVIDER_SECOND_B = 8'h03;
  logic TABLE_WE = 0, LEVEL_WE = 0, DIRECT_INPUT_SELECT = 0, SAMPLE_HOLD_SELECT = 0;
  logic [4:0] TABLE_ADDR = 0;
  entry_t TABLE_WDATA = 0;
  logic [2:0] LEVEL_ADDR = 0, TIMER_CAPTURE;
  logic [9:0] LEVEL_WDATA = 0, DAC_LEVEL;
  logic ENVELOPE_INPUT_SELECT = 0, DIRECT_CHANNEL3_SELECT = 0, TEST_REQUEST_SET = 0;
  logic [1:0] TEST1_CHANNEL_FIELD = 0, TIMER_ROUTE_SELECT_A = 0, TIMER_ROUTE_SELECT_B = 0;
  logic COMPARATOR_INVERT = 0, COMPARATOR_FORCE_ON = 0, DAC_FORCE_ON = 0, TIMER_OUTPUT_MODE = 0;
  logic START_FLAG_CLR = 0, STOP_FLAG_CLR = 0, COMPARATOR_OUT, SENSOR_PATH_EXCITE;
  logic [1:0] CHANNEL_SELECT, tres = 0;
  logic SENSOR_PATH_SAMPLE, DIRECT_PATH, COMMON_DIRECT_INPUT, LC_SENSOR_ENABLE, EXCITATION_PULSE;
  logic COMPARATOR_POWER, DAC_POWER, OSC_ENABLE, SEQUENCE_STOP, TEST0_RESULT_BIT;
  logic TEST1_RESULT_BIT, TEST_CYCLE_REQUEST, TEST_CYCLE_ACTIVE, SEQUENCE_START_FLAG;
  logic SEQUENCE_STOP_FLAG;
  logic [3:0] CHANNEL_RESULT_BIT, last = 0;
  logic [39:0] ain = 0;
  logic [9:0] lvl [8];
  int bad_count = 0, comparisons = 0, seed = 32'hA1F0;
  always #4 SYS_CLK = ~SYS_CLK;
  always #32.3 ACLK_IN = ~ACLK_IN;
  scan_sensor_sequencer dut (.*);
  scan_afe_model afe (.clk(SYS_CLK), .sel(CHANNEL_SELECT), .level(DAC_LEVEL),
    .power(COMPARATOR_POWER), .ain(ain), .cmp_out(COMPARATOR_OUT));
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [9:0] e, input logic [9:0] g, input string n);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic step(input int c);
    repeat (c) @(negedge SYS_CLK);
  endtask : step
  task automatic wait_for(input bit want_ex, output int n);
    n = 0;
    while (!(want_ex ? EXCITATION_PULSE === 1'b1 : SEQUENCE_STOP === 1'b1)) begin
      step(1);
      n++;
      if (n > 600) begin
        bad_count++;
        test_done();
      end
    end
  endtask : wait_for
  task automatic wr(input bit tbl, input logic [4:0] a, input entry_t d);
    TABLE_ADDR = a;
    LEVEL_ADDR = a[2:0];
    TABLE_WDATA = d;
    LEVEL_WDATA = d[9:0];
    TABLE_WE = tbl;
    LEVEL_WE = !tbl;
    step(1);
    TABLE_WE = 0;
    LEVEL_WE = 0;
    step(1);
  endtask : wr
  function automatic entry_t ent(input logic [1:0] c, input logic ts, ex, rs, sp, sl,
                                 input logic [4:0] r);
    return {1'b0, r, sl, sp, 1'b1, ts, rs, 1'b1, ex, 1'b1, c};
  endfunction : ent
  // ****************
  // main sequence
  // ****************
  initial begin
    int n;
    logic [31:0] rv, rw;
    logic [1:0] k, c;
    logic [2:0] li;
    logic ts, tst, req, r;
    step(20);
    chk(0, {CHANNEL_RESULT_BIT, SEQUENCE_STOP_FLAG, SEQUENCE_START_FLAG, TEST_CYCLE_REQUEST,
      LC_SENSOR_ENABLE, EXCITATION_PULSE, SEQUENCE_STOP}, "reset outputs");
    RST_N = 1;
    for (int i = 0; i < 8; i++) begin
      rv = $random(seed);
      lvl[i] = rv[9:0];
      wr(0, 5'(i), {6'h00, lvl[i]});
    end
    wr(1, 0, 16'h0000);
    wr(1, 24, 16'hFFFF);
    FAST_CLOCK_DIV = rv[11:10];
    for (int i = 0; i < 12; i++) begin
      rv = $random(seed);
      rw = $random(seed);
      {k, ts, DIRECT_INPUT_SELECT, SAMPLE_HOLD_SELECT, ENVELOPE_INPUT_SELECT} = rv[5:0];
      {COMPARATOR_INVERT, COMPARATOR_FORCE_ON, DAC_FORCE_ON, TIMER_OUTPUT_MODE} = rv[9:6];
      {TIMER_ROUTE_SELECT_A, TIMER_ROUTE_SELECT_B} = rv[13:10];
      {TEST0_CHANNEL_FIELD, TEST1_CHANNEL_FIELD} = rv[17:14];
      ain = i < 2 ? {40{i == 0}} : {rv[31:24], rw};
      tst = i % 4 == 3;
      req = i % 4 == 2;
      wr(1, 1, ent(k, ts, 1, 0, 0, 1, 1));
      wr(1, 2, ent(k, ts, 0, 1, 0, 0, 3));
      wr(1, 3, ent(k, ts, 0, 1, 1, 0, 0));
      SCAN_ENABLE = 1;
      START_FLAG_CLR = 1;
      STOP_FLAG_CLR = 1;
      TEST_REQUEST_SET = req;
      step(1);
      {START_FLAG_CLR, STOP_FLAG_CLR, TEST_REQUEST_SET} = 3'h0;
      wait_for(1, n);
      step(3);
      c = tst ? (ts ? TEST1_CHANNEL_FIELD : TEST0_CHANNEL_FIELD) : k;
      li = tst ? {2'b11, ts} : {k, last[k]};
      chk(c, CHANNEL_SELECT, "channel");
      chk(lvl[li], DAC_LEVEL, "dac level");
      chk({tst, 3'h7, DIRECT_INPUT_SELECT, !DIRECT_INPUT_SELECT && !SAMPLE_HOLD_SELECT,
        !DIRECT_INPUT_SELECT && SAMPLE_HOLD_SELECT, DIRECT_INPUT_SELECT && ENVELOPE_INPUT_SELECT},
        {TEST_CYCLE_ACTIVE, LC_SENSOR_ENABLE, COMPARATOR_POWER, DAC_POWER, DIRECT_PATH,
        SENSOR_PATH_EXCITE, SENSOR_PATH_SAMPLE, COMMON_DIRECT_INPUT}, "controls");
      r = (ain[c * 10 +: 10] > lvl[li]) ^ COMPARATOR_INVERT;
      if (TIMER_OUTPUT_MODE) chk({1'b0, r, 1'b1}, TIMER_CAPTURE, "capture");
      else chk({1'b0, last[TIMER_ROUTE_SELECT_B], last[TIMER_ROUTE_SELECT_A]}, TIMER_CAPTURE,
        "route");
      wait_for(0, n);
      step(3);
      if (tst) tres[ts] = r;
      else if (DIRECT_INPUT_SELECT && ENVELOPE_INPUT_SELECT) last = {4{r}};
      else last[k] = r;
      chk({last, tres, req, 2'h3}, {CHANNEL_RESULT_BIT, TEST1_RESULT_BIT, TEST0_RESULT_BIT,
        TEST_CYCLE_REQUEST, SEQUENCE_START_FLAG, SEQUENCE_STOP_FLAG}, "results");
      if (!req) chk({2'h0, COMPARATOR_FORCE_ON}, {CHANNEL_SELECT, COMPARATOR_POWER}, "idle");
    end
    FAST_CLOCK_DIV = 0;
    SEQUENCER_REPEAT = 1;
    wait_for(0, n);
    step(2);
    wait_for(0, n);
    chk(1, n < 100, "restart gap");
    SCAN_ENABLE = 0;
    step(3);
    chk(0, {OSC_ENABLE, EXCITATION_PULSE, LC_SENSOR_ENABLE, CHANNEL_SELECT}, "disabled");
    test_done();
  end
endmodule : scan_sensor_sequencer_tb
